// ### rtl/sdcmd_pkg.sv
// constants and types shared by the command decoder and the controller end
// assumes one 10 MHz clock, asynchronous active-low reset
// Summary of operation
// [R1] chip select high: no new command
// [R2] row/column/write strobes select the command
// [R3] activate opens bank row until precharge
// [R4] read/write: column low bits, bit ten autoprecharge
// [R5] precharge: bit ten selects one or all
// [R6] mode load copies address; banks idle
// [R7] burst terminate cuts latest read/write burst
// [R8] byte masks: writes immediate, reads two later
// [R9] refresh: auto, or self refresh if enable falls
// [R10] self refresh internal; only enable matters
// [R11] controller holds self refresh minimum row-active time
// [R12] no command until refresh cycle time passes
// [R13] exit: only no-ops, two minimum, then idle
// [R14] controller refreshes all rows after exit; this controller leaves that refresh to the user
// [R15] power-down entry/exit on enable with no-op
// [R16] enable low mid-burst: clock suspend, resume next
// [R17] power action from current and previous enable
// [R18] controller never issues illegal enable/command pairs; this controller forces only the self refresh exit edge to a no-op
// [R19] enable low makes next edge invalid
// [R20] timings are parameters counted in cycles
// [R21] commands in low-power states change nothing
package sdcmd_pkg;
  localparam int CLK_PERIOD_NS            = 100;
  localparam int MIN_ROW_ACTIVE_TIME_NS   = 42;
  localparam int REFRESH_CYCLE_TIME_NS    = 60;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
  // least times round up [R20]
  localparam int RAS_CYC = (MIN_ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC  = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XSR_RAW = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_EXIT_NOPS = 2;
  localparam int XSR_CYC = (XSR_RAW > MIN_EXIT_NOPS) ? XSR_RAW : MIN_EXIT_NOPS;
  localparam int BURST_LEN   = 4;
  localparam int READ_MASK_DELAY = 2;
  localparam int AP_BIT      = 10;
  localparam int COL_BITS    = 8;
  localparam int ADDR_BITS   = 12;
  localparam int BANKS       = 4;
  localparam logic [11:0] MODE_RESET = 12'h0000;

  typedef enum logic [3:0] {
    SDCMD_INHIBIT   = 4'b1000,
    SDCMD_NOP       = 4'b0111,
    SDCMD_ACTIVATE  = 4'b0011,
    SDCMD_READ      = 4'b0101,
    SDCMD_WRITE     = 4'b0100,
    SDCMD_TERMINATE = 4'b0110,
    SDCMD_PRECHARGE = 4'b0010,
    SDCMD_REFRESH   = 4'b0001,
    SDCMD_MODE_LOAD = 4'b0000
  } sdcmd_cmd_e;

  typedef enum logic [2:0] {
    SDCMD_PS_RUN      = 3'b000,
    SDCMD_PS_POWDOWN  = 3'b001,
    SDCMD_PS_SELFREF  = 3'b010,
    SDCMD_PS_SUSPEND  = 3'b011,
    SDCMD_PS_SR_EXIT  = 3'b100
  } sdcmd_pstate_e;
endpackage

// ### rtl/sdcmd_if.sv
`timescale 1ns/1ps
// pins between controller and command decoder
// assumes both ends share clock; data pins are split into separate to-device and from-device buses
interface sdcmd_if (
  input wire logic clock
);
  logic        clk_enable;
  logic        chip_sel_n;
  logic        row_strobe_n;
  logic        col_strobe_n;
  logic        write_strobe_n;
  logic [1:0]  bank_select;
  logic [11:0] addr_bus;
  logic        low_byte_mask;
  logic        high_byte_mask;
  logic [15:0] dq_to_dev;
  logic [15:0] dq_from_dev;
  logic [1:0]  dq_dev_oe;
  modport dev (
    input  clk_enable, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
    input  bank_select, addr_bus, low_byte_mask, high_byte_mask, dq_to_dev,
    output dq_from_dev, dq_dev_oe
  );
  modport ctl (
    output clk_enable, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
    output bank_select, addr_bus, low_byte_mask, high_byte_mask, dq_to_dev,
    input  dq_from_dev, dq_dev_oe
  );
endinterface // sdcmd_if

// ### rtl/sdcmd_timer.sv
`timescale 1ns/1ps
// down-counter for recovery periods
// assumes load is a single-cycle strobe from the owner; the count runs down on every edge and holds at zero
module sdcmd_timer (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic            busy
);
  logic [7:0] count_ff;
  wire  [7:0] nxt_count = load ? load_val : (count_ff != 8'h00 ? count_ff - 8'h01 : 8'h00);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) count_ff <= 8'h00;
    else        count_ff <= nxt_count;
  end
  assign busy = (count_ff != 8'h00);
endmodule // sdcmd_timer

// ### rtl/sdcmd_dev.sv
`timescale 1ns/1ps
// device end: command decode, bank rows, byte masks, clock-enable power states
// assumes the controller drives every pin synchronously to clock
module sdcmd_dev (
  input  wire logic        clock,
  input  wire logic        rst_n,
  sdcmd_if.dev             pins,
  output logic [3:0]       bank_open_ff,
  output logic [47:0]      open_rows_ff,
  output logic [11:0]      mode_reg_ff,
  output logic [2:0]       pstate_ff,
  output logic             burst_active_ff,
  output logic             burst_is_write_ff,
  output logic [7:0]       burst_col_ff,
  output logic             burst_autopre_ff,
  output logic [1:0]       burst_bank_ff,
  output logic [1:0]       wr_byte_en_ff,
  output logic [15:0]      wr_data_ff,
  output logic             refresh_pulse_ff,
  output logic             busy_ff
);
  // enable counts as high before reset, so the first edge after release is valid
  logic       cke_prev_ff;
  logic [1:0] rmask_pipe_ff [0:1];
  logic [2:0] burst_left_ff;
  wire  cke  = pins.clk_enable;
  wire  [3:0] cmd_bits = {pins.chip_sel_n, pins.row_strobe_n, pins.col_strobe_n,
                          pins.write_strobe_n};
  // chip select high masks the strobes, so a stray strobe pattern is never decoded
  function automatic logic [3:0] decode_cmd(input logic [3:0] pins_in);
    logic [3:0] code;
    if (pins_in[3]) begin
      code = 4'b1000; // [R1]
    end else begin
      code = pins_in; // [R2]
    end
    return code;
  endfunction
  wire  is_inh = pins.chip_sel_n; // [R1]
  wire  [3:0] cmd = decode_cmd(cmd_bits); // [R2]
  wire  is_nop  = is_inh || (cmd == sdcmd_pkg::SDCMD_NOP);
  wire  all_idle = (bank_open_ff == 4'h0) && !burst_active_ff && !busy_ff;
  wire  run = (pstate_ff == sdcmd_pkg::SDCMD_PS_RUN);
  // valid edge needs enable high now and before, and no recovery pending [R17] [R19]
  wire  tmr_busy;
  // an edge while the refresh or exit timer runs is not executable, so commands that
  // break the recovery rule are dropped instead of corrupting bank state
  wire  exec = run && cke_prev_ff && cke && !tmr_busy;
  logic tmr_load;
  logic [7:0] tmr_val;
  logic [2:0] nxt_pstate;

  // one shared timer: refresh, self-refresh entry and exit recovery never overlap
  sdcmd_timer u_timer (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .busy     (tmr_busy)
  );

  // power-state decision from previous and current enable [R17]
  always_comb begin
    nxt_pstate = pstate_ff;
    tmr_load   = 1'b0;
    tmr_val    = 8'h00;
    unique case (pstate_ff)
      sdcmd_pkg::SDCMD_PS_RUN: begin
        if (cke_prev_ff && !cke) begin
          if (burst_active_ff) nxt_pstate = sdcmd_pkg::SDCMD_PS_SUSPEND; // [R16]
          else if (all_idle && cmd == sdcmd_pkg::SDCMD_REFRESH) begin
            nxt_pstate = sdcmd_pkg::SDCMD_PS_SELFREF; // [R9]
            tmr_load   = 1'b1;
            tmr_val    = 8'(sdcmd_pkg::RC_CYC); // [R12]
          end else if (all_idle && is_nop) nxt_pstate = sdcmd_pkg::SDCMD_PS_POWDOWN; // [R15]
        end else if (exec && cmd == sdcmd_pkg::SDCMD_REFRESH) begin
          tmr_load = 1'b1;
          tmr_val  = 8'(sdcmd_pkg::RC_CYC);
        end
      end
      sdcmd_pkg::SDCMD_PS_POWDOWN:
        if (cke && is_nop) nxt_pstate = sdcmd_pkg::SDCMD_PS_RUN; // [R15]
      sdcmd_pkg::SDCMD_PS_SELFREF:
        if (cke && is_nop) begin // [R10]
          nxt_pstate = sdcmd_pkg::SDCMD_PS_SR_EXIT;
          tmr_load   = 1'b1;
          tmr_val    = 8'(sdcmd_pkg::XSR_CYC); // [R13]
        end
      sdcmd_pkg::SDCMD_PS_SUSPEND:
        if (cke) nxt_pstate = sdcmd_pkg::SDCMD_PS_RUN; // [R16]
      sdcmd_pkg::SDCMD_PS_SR_EXIT:
        if (!tmr_busy) nxt_pstate = sdcmd_pkg::SDCMD_PS_RUN; // [R13]
      default: nxt_pstate = sdcmd_pkg::SDCMD_PS_RUN;
    endcase
  end

  // mode load outside all-idle is ignored rather than flagged; the controller owns that
  wire do_act  = exec && cmd == sdcmd_pkg::SDCMD_ACTIVATE;
  wire do_rd   = exec && cmd == sdcmd_pkg::SDCMD_READ;
  wire do_wr   = exec && cmd == sdcmd_pkg::SDCMD_WRITE;
  wire do_pre  = exec && cmd == sdcmd_pkg::SDCMD_PRECHARGE;
  wire do_term = exec && cmd == sdcmd_pkg::SDCMD_TERMINATE;
  wire do_mode = exec && cmd == sdcmd_pkg::SDCMD_MODE_LOAD && all_idle;
  // bit ten is auto precharge on accesses and all-bank select on precharge
  wire pre_all = pins.addr_bus[sdcmd_pkg::AP_BIT];
  // suspend freezes the burst; low-power states see no commands [R21]
  wire burst_run = run && cke && burst_active_ff;
  wire burst_end = burst_run && burst_left_ff == 3'd1;

  // the row stays in its register after close; only the open flag is cleared
  genvar b;
  generate
    for (b = 0; b < sdcmd_pkg::BANKS; b++) begin : g_bank
      wire hit = pins.bank_select == 2'(b);
      wire open_now = do_act && hit;
      wire close_now = (do_pre && (pre_all || hit)) // [R5]
                     || (burst_end && burst_autopre_ff && burst_bank_ff == 2'(b)); // [R4]
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          bank_open_ff[b] <= 1'b0;
          open_rows_ff[b*12 +: 12] <= 12'h000;
        end else if (open_now) begin // [R3]
          bank_open_ff[b] <= 1'b1;
          open_rows_ff[b*12 +: 12] <= pins.addr_bus;
        end else if (close_now) begin
          bank_open_ff[b] <= 1'b0;
        end
      end
    end
  endgenerate

  wire new_burst = do_rd || do_wr;
  wire [1:0] cur_mask = {pins.high_byte_mask, pins.low_byte_mask};
  // a new access wins over terminate on one edge: the latest command owns the burst

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pstate_ff         <= sdcmd_pkg::SDCMD_PS_RUN;
      cke_prev_ff       <= 1'b1;
      mode_reg_ff       <= sdcmd_pkg::MODE_RESET;
      burst_active_ff   <= 1'b0;
      burst_is_write_ff <= 1'b0;
      burst_col_ff      <= 8'h00;
      burst_autopre_ff  <= 1'b0;
      burst_bank_ff     <= 2'b00;
      burst_left_ff     <= 3'd0;
      refresh_pulse_ff  <= 1'b0;
      busy_ff           <= 1'b0;
    end else begin
      pstate_ff        <= nxt_pstate;
      cke_prev_ff      <= cke;
      refresh_pulse_ff <= (exec && cmd == sdcmd_pkg::SDCMD_REFRESH) // [R9]
                          || (pstate_ff == sdcmd_pkg::SDCMD_PS_SELFREF && !tmr_busy); // [R10]
      busy_ff          <= tmr_busy || tmr_load;
      if (do_mode) mode_reg_ff <= pins.addr_bus; // [R6]
      if (new_burst) begin // [R4]
        burst_active_ff   <= 1'b1;
        burst_is_write_ff <= do_wr;
        burst_col_ff      <= pins.addr_bus[sdcmd_pkg::COL_BITS-1:0];
        burst_autopre_ff  <= pins.addr_bus[sdcmd_pkg::AP_BIT];
        burst_bank_ff     <= pins.bank_select;
        burst_left_ff     <= 3'(sdcmd_pkg::BURST_LEN);
      end else if (do_term || burst_end ||
                   (do_pre && (pre_all || pins.bank_select == burst_bank_ff))) begin
        burst_active_ff <= 1'b0; // [R7]
        burst_left_ff   <= 3'd0;
      end else if (burst_run) begin
        burst_left_ff <= burst_left_ff - 3'd1;
        burst_col_ff  <= burst_col_ff + 8'h01;
      end
    end
  end

  // write mask acts now, read mask two edges later [R8]
  // masked lanes still capture data; the enable tells the array which bytes to keep
  wire wr_beat = do_wr || (burst_run && burst_is_write_ff && !do_term);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_byte_en_ff    <= 2'b00;
      wr_data_ff       <= 16'h0000;
      rmask_pipe_ff[0] <= 2'b11;
      rmask_pipe_ff[1] <= 2'b11;
    end else begin
      wr_byte_en_ff    <= wr_beat ? ~cur_mask : 2'b00;
      wr_data_ff       <= pins.dq_to_dev;
      rmask_pipe_ff[0] <= cur_mask;
      rmask_pipe_ff[1] <= rmask_pipe_ff[0];
    end
  end

  // read lanes are registered once more so the enable comes straight from a flop
  logic [1:0] rd_oe_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_oe_ff <= 2'b00;
    end else begin
      rd_oe_ff <= (burst_active_ff && !burst_is_write_ff) ? ~rmask_pipe_ff[1] : 2'b00;
    end
  end
  assign pins.dq_dev_oe   = rd_oe_ff; // [R8]
  assign pins.dq_from_dev = {open_rows_ff[3:0], burst_col_ff, 4'h0};
endmodule // sdcmd_dev

// ### rtl/sdcmd_ctl.sv
`timescale 1ns/1ps
// controller end: issues one user command, sequences self-refresh timing
// assumes user holds req until ack
module sdcmd_ctl (
  input  wire logic        clock,
  input  wire logic        rst_n,
  sdcmd_if.ctl             pins,
  input  wire logic        req,
  input  wire logic [3:0]  req_cmd,
  input  wire logic [1:0]  req_bank,
  input  wire logic [11:0] req_addr,
  input  wire logic [1:0]  req_mask,
  input  wire logic [15:0] req_wdata,
  input  wire logic        req_cke,
  output logic             ack_ff
);
  logic        cke_ff;
  logic [3:0]  cmd_ff;
  logic [1:0]  bank_ff;
  logic [11:0] addr_ff;
  logic [1:0]  mask_ff;
  logic [15:0] wdata_ff;
  logic        in_sr_ff;
  logic [7:0]  wait_ff;
  wire  hold = wait_ff != 8'h00;
  // exit from self refresh: no-ops through exit time [R13]; entry: hold row-active [R11]
  wire  take = req && !ack_ff && !hold;
  wire  sr_entry = take && cke_ff && !req_cke && req_cmd == sdcmd_pkg::SDCMD_REFRESH;
  wire  sr_exit  = take && in_sr_ff && req_cke;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_ff <= 1'b1; cmd_ff <= sdcmd_pkg::SDCMD_INHIBIT; bank_ff <= 2'b00;
      addr_ff <= 12'h000; mask_ff <= 2'b11; wdata_ff <= 16'h0000;
      ack_ff <= 1'b0; in_sr_ff <= 1'b0; wait_ff <= 8'h00;
    end else begin
      ack_ff <= take;
      cmd_ff <= sdcmd_pkg::SDCMD_INHIBIT;
      if (hold) wait_ff <= wait_ff - 8'h01;
      if (take) begin
        cke_ff   <= req_cke;
        // exit edge carries only a no-op; leaving states need no-op pairs [R18]
        cmd_ff   <= sr_exit ? sdcmd_pkg::SDCMD_NOP : req_cmd;
        bank_ff  <= req_bank;
        addr_ff  <= req_addr;
        mask_ff  <= req_mask;
        wdata_ff <= req_wdata;
      end
      if (sr_entry) begin
        in_sr_ff <= 1'b1;
        wait_ff  <= 8'(sdcmd_pkg::RAS_CYC > sdcmd_pkg::RC_CYC ? sdcmd_pkg::RAS_CYC
                                                              : sdcmd_pkg::RC_CYC); // [R12]
      end else if (sr_exit) begin
        in_sr_ff <= 1'b0;
        wait_ff  <= 8'(sdcmd_pkg::XSR_CYC + 1); // [R13] user should refresh next [R14]
      end
    end
  end
  assign pins.clk_enable     = cke_ff;
  assign pins.chip_sel_n     = cmd_ff[3];
  assign pins.row_strobe_n   = cmd_ff[2];
  assign pins.col_strobe_n   = cmd_ff[1];
  assign pins.write_strobe_n = cmd_ff[0];
  assign pins.bank_select    = bank_ff;
  assign pins.addr_bus       = addr_ff;
  assign pins.low_byte_mask  = mask_ff[0];
  assign pins.high_byte_mask = mask_ff[1];
  assign pins.dq_to_dev      = wdata_ff;
endmodule // sdcmd_ctl

// ### verification/sdcmd_pins_asserts.sv
// checker for the pins between the controller end and the command decoder
// assumes the testbench instantiates it beside the interface, one clock domain
`timescale 1ns/1ps
module sdcmd_pins_asserts (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       clk_enable,
  input wire logic       chip_sel_n,
  input wire logic       row_strobe_n,
  input wire logic       col_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       low_byte_mask,
  input wire logic [1:0] dq_dev_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [2:0] strobes;
  logic       cmd_idle;
  logic       is_ref;
  logic       is_read;
  logic       sr_entry;
  logic       cke_ff;
  logic       sr_ff;
  logic [3:0] rd_age_ff;
  assign strobes  = {row_strobe_n, col_strobe_n, write_strobe_n};
  assign cmd_idle = chip_sel_n || (strobes == 3'h7);
  assign is_ref   = !chip_sel_n && (strobes == 3'h1);
  assign is_read  = !chip_sel_n && (strobes == 3'h5);
  assign sr_entry = cke_ff && !clk_enable && is_ref;
  // age counts only edges with enable high, so a suspended burst keeps its window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_ff    <= 1'h1;
      sr_ff     <= 1'h0;
      rd_age_ff <= 4'hf;
    end else begin
      cke_ff    <= clk_enable;
      sr_ff     <= sr_entry || (sr_ff && !clk_enable);
      rd_age_ff <= (is_read && clk_enable) ? 4'h0 :
                   (clk_enable && rd_age_ff != 4'hf) ? rd_age_ff + 4'h1 : rd_age_ff;
    end
  end
  a_cmd_one_cycle: assert property (!chip_sel_n |=> chip_sel_n)
    else $error("command pins held beyond one cycle");
  a_sr_hold_low: assert property (sr_entry |=> !clk_enable)
    else $error("self refresh left too early");
  a_sr_no_cmd: assert property (sr_entry |=> cmd_idle)
    else $error("command during refresh recovery");
  a_sr_exit_nops: assert property (sr_ff && clk_enable |-> cmd_idle ##1 cmd_idle)
    else $error("command during self refresh exit");
  a_sr_quiet_oe: assert property (sr_ff |-> dq_dev_oe == 2'h0)
    else $error("data driven in self refresh");
  a_oe_mask_low: assert property ($rose(dq_dev_oe[0]) |->
    !$past(low_byte_mask, 2) || !$past(low_byte_mask, 3))
    else $error("low byte driven while masked");
  a_oe_after_read: assert property (dq_dev_oe != 2'h0 |-> rd_age_ff < 4'ha)
    else $error("data driven without a read");
  a_frozen_oe: assert property (!$past(clk_enable) && !$past(clk_enable, 2)
    |-> $stable(dq_dev_oe))
    else $error("outputs moved on an invalid edge");
  c_sr_entry: cover property (sr_entry);
  c_sr_exit: cover property (sr_ff && clk_enable);
  c_read_oe: cover property ($rose(dq_dev_oe[0]));
  c_pd_entry: cover property (cke_ff && !clk_enable && cmd_idle);
endmodule // sdcmd_pins_asserts

// ### verification/sdram_command_and_cke_control_tb.sv
// bench: controller end drives the command decoder through the shared pins
// assumes package, interface, timer and both ends are compiled first
`timescale 1ns/1ps
module sdram_command_and_cke_control_tb;
  logic        clock, rst_n, req, req_cke, ack, b_act, b_ap, ref_p;
  logic [3:0]  req_cmd, bank_open, exp_open;
  logic [1:0]  req_bank, req_mask, wr_be, b;
  logic [11:0] req_addr, mode_reg, r;
  logic [15:0] req_wdata;
  logic [47:0] rows;
  logic [2:0]  pstate;
  logic [7:0]  b_col;
  logic [31:0] seed;
  int          mismatches, total_checks, n;
  sdcmd_if bus (.clock(clock));
  sdcmd_dev sdcmd_dev_inst (.clock(clock), .rst_n(rst_n), .pins(bus.dev),
    .bank_open_ff(bank_open), .open_rows_ff(rows), .mode_reg_ff(mode_reg),
    .pstate_ff(pstate), .burst_active_ff(b_act), .burst_is_write_ff(),
    .burst_col_ff(b_col), .burst_autopre_ff(b_ap), .burst_bank_ff(),
    .wr_byte_en_ff(wr_be), .wr_data_ff(), .refresh_pulse_ff(ref_p), .busy_ff());
  sdcmd_ctl sdcmd_ctl_inst (.clock(clock), .rst_n(rst_n), .pins(bus.ctl), .req(req),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_mask(req_mask),
    .req_wdata(req_wdata), .req_cke(req_cke), .ack_ff(ack));
  sdcmd_pins_asserts sdcmd_pins_asserts_inst (.clock(clock), .rst_n(rst_n),
    .clk_enable(bus.clk_enable), .chip_sel_n(bus.chip_sel_n),
    .row_strobe_n(bus.row_strobe_n), .col_strobe_n(bus.col_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .low_byte_mask(bus.low_byte_mask),
    .dq_dev_oe(bus.dq_dev_oe));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // a low mask bit enables its byte lane
  function automatic logic [1:0] lanes(input logic [1:0] m);
    return ~m;
  endfunction
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // returns one edge after the device has seen the pins
  task automatic cmd(input logic [3:0] c, input logic [1:0] bk, input logic [11:0] a,
                     input logic [1:0] m, input logic k);
    @(posedge clock);
    req       <= 1'h1;
    req_cmd   <= c;
    req_bank  <= bk;
    req_addr  <= a;
    req_mask  <= m;
    req_cke   <= k;
    req_wdata <= 16'(xs());
    for (n = 0; n < 20 && ack !== 1'h1; n++)
      @(negedge clock);
    if (ack !== 1'h1) begin
      mismatches++;
      final_report();
    end
    @(posedge clock);
    req <= 1'h0;
    @(negedge clock);
  endtask
  task automatic wait_ps(input logic [2:0] p);
    for (n = 0; n < 20 && pstate !== p; n++)
      @(negedge clock);
    chk(pstate, p);
    if (pstate !== p)
      final_report();
  endtask
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
  initial begin
    seed = 32'h0000_0026;
    {rst_n, req, req_bank, req_addr, req_wdata} = '0;
    {req_cmd, req_mask, req_cke} = 7'h47;
    exp_open = 4'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    @(negedge clock);
    chk(pstate, sdcmd_pkg::SDCMD_PS_RUN);
    for (int i = 0; i < 8; i++) begin
      b = 2'(i);
      r = 12'(xs());
      if (exp_open[b]) begin
        cmd(sdcmd_pkg::SDCMD_PRECHARGE, b, r & 12'hbff, 2'h3, 1'h1);
        exp_open[b] = 1'h0;
        chk(bank_open, exp_open);
      end
      cmd(sdcmd_pkg::SDCMD_ACTIVATE, b, r, 2'h3, 1'h1);
      exp_open[b] = 1'h1;
      chk(bank_open, exp_open);
      chk(rows[b*12 +: 12], r);
    end
    for (int i = 0; i < 4; i++) begin
      r = 12'(xs()) & 12'hbff;
      cmd(sdcmd_pkg::SDCMD_WRITE, 2'(i), r, 2'(i), 1'h1);
      chk(wr_be, lanes(2'(i)));
      chk(b_col, r[7:0]);
      r = 12'(xs()) & 12'hbff;
      cmd(sdcmd_pkg::SDCMD_READ, 2'(i), r, 2'(i), 1'h1);
      chk(b_act, 1'h1);
      chk(b_ap, 1'h0);
      cmd(sdcmd_pkg::SDCMD_TERMINATE, 2'h0, 12'(xs()), 2'h3, 1'h1);
      chk(b_act, 1'h0);
    end
    cmd(sdcmd_pkg::SDCMD_READ, 2'h1, 12'h400, 2'h0, 1'h1);
    chk(b_ap, 1'h1);
    for (n = 0; n < 20 && bank_open[1] !== 1'h0; n++)
      @(negedge clock);
    chk(bank_open, 4'hd);
    cmd(sdcmd_pkg::SDCMD_PRECHARGE, 2'(xs()), 12'h400, 2'h3, 1'h1);
    chk(bank_open, 4'h0);
    r = 12'(xs());
    cmd(sdcmd_pkg::SDCMD_MODE_LOAD, 2'h0, r, 2'h3, 1'h1);
    chk(mode_reg, r);
    // chip select high with any strobes, then a no-op, must leave state alone
    for (int i = 0; i < 5; i++) begin
      cmd((i == 4) ? 4'h7 : {1'h1, 3'(xs())}, 2'(xs()), 12'(xs()), 2'h3, 1'h1);
      chk(mode_reg, r);
      chk(bank_open, 4'h0);
    end
    cmd(sdcmd_pkg::SDCMD_REFRESH, 2'h0, 12'h000, 2'h3, 1'h1);
    chk(ref_p, 1'h1);
    cmd(sdcmd_pkg::SDCMD_REFRESH, 2'h0, 12'h000, 2'h3, 1'h0);
    chk(pstate, sdcmd_pkg::SDCMD_PS_SELFREF);
    cmd(sdcmd_pkg::SDCMD_ACTIVATE, 2'h2, 12'(xs()), 2'h3, 1'h0);
    chk(bank_open, 4'h0);
    cmd(4'h7, 2'h0, 12'h000, 2'h3, 1'h1);
    chk(pstate, sdcmd_pkg::SDCMD_PS_SR_EXIT);
    wait_ps(sdcmd_pkg::SDCMD_PS_RUN);
    cmd(sdcmd_pkg::SDCMD_REFRESH, 2'h0, 12'h000, 2'h3, 1'h1);
    chk(ref_p, 1'h1);
    cmd(4'h7, 2'h0, 12'h000, 2'h3, 1'h0);
    chk(pstate, sdcmd_pkg::SDCMD_PS_POWDOWN);
    cmd(4'h7, 2'h0, 12'h000, 2'h3, 1'h1);
    chk(pstate, sdcmd_pkg::SDCMD_PS_RUN);
    cmd(sdcmd_pkg::SDCMD_ACTIVATE, 2'h0, 12'(xs()), 2'h3, 1'h1);
    cmd(sdcmd_pkg::SDCMD_READ, 2'h0, 12'h000, 2'h0, 1'h1);
    cmd(4'h7, 2'h0, 12'h000, 2'h0, 1'h0);
    chk(pstate, sdcmd_pkg::SDCMD_PS_SUSPEND);
    cmd(4'h7, 2'h0, 12'h000, 2'h0, 1'h1);
    chk(pstate, sdcmd_pkg::SDCMD_PS_RUN);
    repeat (8) @(negedge clock);
    final_report();
  end
endmodule // sdram_command_and_cke_control_tb
